// ===== rtl/scc_pkg.sv
// Operation
// - Word length is the word length field plus one, four to thirty-two bits.
// - Four-wire format: serial clock idles at the clock idle level.
// - Four-wire format: clock phase bit picks one of two sampling phases.
// - Bit rate is clock over prescale divisor (rounded down to even, at least two) times one plus rate field.
// - Three-wire format: command length is command length field plus one, four to thirty-two bits.
// - Frame format code zero is four-wire, code two is three-wire.
// - Four-wire master mode: duplex, transmit only, receive only, combined.
// - Target one select pin is asserted when its bit is zero.
// - Serial traffic runs only while the port enable bit is set.
// - Master/slave select zero means master, one means slave.
// - Slave with output disable set leaves the data output undriven.
// - Received elements follow the receive byte and bit order field.
// - Three-wire format inserts one wait state when wait bit is set.
// - Receive trigger at 1, 4 or 8 elements for codes 0 to 2.
// - Transmit trigger at 1, 4 or 8 elements for codes 0 to 2.
// - Four-wire format inserts frame gap wait states between frames; the code inserts them in master mode only.
// - Transmitted elements follow the transmit byte and bit order field.
// - Input delay bit adds two clock cycles on the data input path.
// - Three-wire sends command length bits, then receives a word.
// - A changed transfer mode takes effect at the next word.
package scc_pkg;
	localparam logic [7:0]  ADDR_CTRL_A    = 8'h00;
	localparam logic [7:0]  ADDR_CTRL_B    = 8'h04;
	localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
	localparam logic [7:0]  ADDR_PRESCALE  = 8'h10;
	localparam logic [31:0] CTRL_A_RESET   = 32'h1c000000;
	localparam logic [31:0] CTRL_B_RESET   = 32'h00000000;
	localparam logic [7:0]  PRESCALE_RESET = 8'h00;
	localparam int WLEN_LSB   = 0;
	localparam int IDLE_BIT   = 6;
	localparam int PHASE_BIT  = 7;
	localparam int RATE_LSB   = 8;
	localparam int CMDLEN_LSB = 16;
	localparam int FMT_LSB    = 21;
	localparam int MODE_LSB   = 23;
	localparam int TSEL_BIT   = 26;
	localparam int EN_BIT     = 1;
	localparam int MS_BIT     = 2;
	localparam int SOD_BIT    = 3;
	localparam int RORD_LSB   = 4;
	localparam int WAIT_BIT   = 6;
	localparam int RTRIG_LSB  = 7;
	localparam int TTRIG_LSB  = 10;
	localparam int GAP_LSB    = 14;
	localparam int TORD_LSB   = 18;
	localparam int DELAY_BIT  = 21;
	localparam logic [1:0] FMT_THREE   = 2'h2;
	localparam logic [1:0] MODE_TXONLY = 2'h1;
	localparam logic [1:0] MODE_RXONLY = 2'h2;
	localparam logic [5:0] MIN_LEN     = 6'h04;
	localparam int IN_DELAY_CYCLES = 2;
	localparam int TRIG_LVL0 = 1;
	localparam int TRIG_LVL1 = 4;
	localparam int TRIG_LVL2 = 8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE, ST_SHIFT, ST_WAIT, ST_RECV, ST_GAP
	} scc_state_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} scc_word_t;
endpackage : scc_pkg

// ===== rtl/scc_link.sv
`timescale 1ns/1ns
module scc_link #(
	parameter int AW = 8,
	parameter int LW = 5
) (
	// Clock and reset
	input  wire logic              MCLK,
	input  wire logic              RST,
	// AXI4-Lite slave
	input  wire logic [AW-1:0]     S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output      logic              S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output      logic              S_AXI_WREADY,
	output      logic [1:0]        S_AXI_BRESP,
	output      logic              S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [AW-1:0]     S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output      logic              S_AXI_ARREADY,
	output      logic [31:0]       S_AXI_RDATA,
	output      logic [1:0]        S_AXI_RRESP,
	output      logic              S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	// Word streams and FIFO levels
	input  wire scc_pkg::scc_word_t TX_WORD,
	output      logic              TX_TAKE,
	output      scc_pkg::scc_word_t RX_WORD,
	input  wire logic [LW-1:0]     TX_LEVEL,
	input  wire logic [LW-1:0]     RX_LEVEL,
	output      logic              TX_TRIGGER,
	output      logic              RX_TRIGGER,
	// Serial pins
	input  wire logic              SCLK_I,
	output      logic              SCLK_O,
	output      logic              SCLK_OE,
	output      logic              SDO_O,
	output      logic              SDO_OE,
	input  wire logic              SDI_I,
	input  wire logic              SS_N_I,
	output      logic              CS1_N_O
);
	import scc_pkg::*;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	function automatic logic [31:0] scc_strb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : scc_strb

	function automatic logic [5:0] scc_len(input logic [4:0] code);
		logic [5:0] r;
		r = (code < 5'h03) ? MIN_LEN : {1'b0, code} + 6'h01;
		return r;
	endfunction : scc_len

	// Code 2'b10 on odd sizes is a software fault and is not corrected
	function automatic logic [31:0] scc_order(input logic [31:0] w,
		input logic [5:0] len, input logic [1:0] code);
		logic [31:0] r;
		r = w;
		unique case (code)
			2'b00: r = w;
			2'b01: r = {w[7:0], w[15:8], w[23:16], w[31:24]}
				>> (6'd32 - len);
			2'b10: begin
				for (int i = 0; i < 32; i++) begin
					r[i] = w[(i & ~7) | (7 - (i & 7))];
				end
			end
			2'b11: begin
				for (int i = 0; i < 32; i++) begin
					r[i] = w[31 - i];
				end
				r = r >> (6'd32 - len);
			end
		endcase
		return r;
	endfunction : scc_order

	function automatic logic scc_trig(input logic [LW-1:0] lvl,
		input logic [2:0] code);
		logic r;
		unique case (code)
			3'h0: r = 32'(lvl) >= TRIG_LVL0;
			3'h1: r = 32'(lvl) >= TRIG_LVL1;
			3'h2: r = 32'(lvl) >= TRIG_LVL2;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : scc_trig

	logic [31:0] ctrl_a_reg;
	logic [31:0] ctrl_b_reg;
	logic [7:0]  psc_reg;
	logic        aw_held_reg;
	logic [AW-1:0] aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic [2:0]  in_meta_reg;
	logic [2:0]  in_sync_reg;
	logic [1:0]  dly_reg;
	logic        sclk_prev_reg;
	scc_state_t  state_reg;
	logic [15:0] half_cnt_reg;
	logic        sclk_reg;
	logic        out_reg;
	logic [31:0] tx_sh_reg;
	logic [31:0] rx_sh_reg;
	logic [5:0]  bit_cnt_reg;
	logic [4:0]  gap_cnt_reg;
	logic [1:0]  mode_reg;
	scc_word_t   rx_word_reg;

	// Field decode
	wire [5:0] wlen     = scc_len(ctrl_a_reg[WLEN_LSB +: 5]);
	wire [5:0] cmd_len  = scc_len(ctrl_a_reg[CMDLEN_LSB +: 5]);
	wire       three    = ctrl_a_reg[FMT_LSB +: 2] == FMT_THREE;
	wire [7:0] rate     = ctrl_a_reg[RATE_LSB +: 8];
	wire [1:0] mode_fld = ctrl_a_reg[MODE_LSB +: 2];
	wire       en       = ctrl_b_reg[EN_BIT];
	wire       master   = !ctrl_b_reg[MS_BIT];
	wire       slave_output_disable      = ctrl_b_reg[SOD_BIT];
	wire       wait_en  = ctrl_b_reg[WAIT_BIT];
	wire [3:0] gap      = ctrl_b_reg[GAP_LSB +: 4];
	wire       delay_en = ctrl_b_reg[DELAY_BIT];
	// Three-wire always runs clock mode zero
	wire idle_lvl = three ? 1'b0 : ctrl_a_reg[IDLE_BIT];
	wire cpha     = three ? 1'b0 : ctrl_a_reg[PHASE_BIT];

	// AXI4-Lite slave
	wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_hs  = S_AXI_WVALID && S_AXI_WREADY;
	wire aw_ok = aw_held_reg || aw_hs;
	wire w_ok  = w_held_reg || w_hs;
	wire do_wr = aw_ok && w_ok && !bvalid_reg;
	wire [AW-1:0] wr_addr = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR;
	wire [31:0]   wr_data = w_held_reg ? w_data_reg : S_AXI_WDATA;
	wire [3:0]    wr_strb = w_held_reg ? w_strb_reg : S_AXI_WSTRB;
	wire [7:0]    wr_idx  = 8'({wr_addr[AW-1:2], 2'b00});
	wire [7:0]    rd_idx  = 8'({S_AXI_ARADDR[AW-1:2], 2'b00});
	wire wr_a = do_wr && wr_idx == ADDR_CTRL_A;
	wire wr_b = do_wr && wr_idx == ADDR_CTRL_B;
	wire wr_p = do_wr && wr_idx == ADDR_PRESCALE;
	wire wr_map = wr_a || wr_b || wr_p || wr_idx == ADDR_STATUS;
	assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
	assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
	assign S_AXI_ARREADY = !rvalid_reg;
	assign S_AXI_BVALID  = bvalid_reg;
	assign S_AXI_BRESP   = bresp_reg;
	assign S_AXI_RVALID  = rvalid_reg;
	assign S_AXI_RDATA   = rdata_reg;
	assign S_AXI_RRESP   = rresp_reg;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end else if (do_wr) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			bvalid_reg  <= 1'b1;
			bresp_reg   <= wr_map ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (aw_hs) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (w_hs) begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (bvalid_reg && S_AXI_BREADY) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Control registers
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ctrl_a_reg <= CTRL_A_RESET;
			ctrl_b_reg <= CTRL_B_RESET;
			psc_reg    <= PRESCALE_RESET;
		end else begin
			if (wr_a) begin
				ctrl_a_reg <= scc_strb(ctrl_a_reg, wr_data, wr_strb);
			end
			if (wr_b) begin
				ctrl_b_reg <= scc_strb(ctrl_b_reg, wr_data, wr_strb);
			end
			if (wr_p && wr_strb[0]) begin
				psc_reg <= wr_data[7:0];
			end
		end
	end

	wire busy = state_reg != ST_IDLE;
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= RESP_OKAY;
			unique case (rd_idx)
				ADDR_CTRL_A:   rdata_reg <= ctrl_a_reg;
				ADDR_CTRL_B:   rdata_reg <= ctrl_b_reg;
				ADDR_PRESCALE: rdata_reg <= {24'h0, psc_reg};
				ADDR_STATUS:   rdata_reg <= {29'h0, TX_TRIGGER,
					RX_TRIGGER, busy};
				default: begin
					rdata_reg <= 32'h0;
					rresp_reg <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && S_AXI_RREADY) begin
			rvalid_reg <= 1'b0;
		end
	end

	// FIFO level triggers
	assign RX_TRIGGER = scc_trig(RX_LEVEL, ctrl_b_reg[RTRIG_LSB +: 3]);
	assign TX_TRIGGER = scc_trig(TX_LEVEL, ctrl_b_reg[TTRIG_LSB +: 3]);

	// Pin synchronisers and input delay
	always_ff @(posedge MCLK) begin
		if (RST) begin
			in_meta_reg   <= 3'h4;
			in_sync_reg   <= 3'h4;
			dly_reg       <= 2'h0;
			sclk_prev_reg <= 1'b0;
		end else begin
			in_meta_reg   <= {SS_N_I, SCLK_I, SDI_I};
			in_sync_reg   <= in_meta_reg;
			dly_reg       <= {dly_reg[0], in_sync_reg[0]};
			sclk_prev_reg <= in_sync_reg[1];
		end
	end
	// Delaying data only shifts the sample point against the clock
	wire sdi = delay_en ? dly_reg[IN_DELAY_CYCLES-1] : in_sync_reg[0];
	wire selected = !in_sync_reg[2];

	// Bit timing: half period is half the even divisor times (1 + rate)
	wire [7:0]  psc_eff  = (psc_reg < 8'h02) ? 8'h02 : {psc_reg[7:1], 1'b0};
	wire [15:0] half_len = 16'(psc_eff[7:1] * ({1'b0, rate} + 9'h001));
	wire m_run  = en && master && busy;
	wire tick   = m_run && half_cnt_reg == half_len - 16'h0001;
	wire toggle = state_reg == ST_SHIFT || state_reg == ST_RECV;
	wire s_edge = !master && selected && in_sync_reg[1] != sclk_prev_reg;
	wire lead   = master ? (tick && toggle && sclk_reg == idle_lvl)
		: (s_edge && sclk_prev_reg == idle_lvl);
	wire trail  = master ? (tick && toggle && sclk_reg != idle_lvl)
		: (s_edge && sclk_prev_reg != idle_lvl);
	wire sample = cpha ? trail : lead;
	wire shiftv = cpha ? lead : trail;

	always_ff @(posedge MCLK) begin
		if (RST || !m_run || tick) begin
			half_cnt_reg <= 16'h0;
		end else begin
			half_cnt_reg <= half_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			sclk_reg <= 1'b0;
		end else if (!m_run) begin
			sclk_reg <= idle_lvl;
		end else if (tick && toggle) begin
			sclk_reg <= !sclk_reg;
		end
	end

	// Word start and shift engine
	wire m_need = three || mode_fld != MODE_RXONLY;
	wire m_start = en && master && !busy && (TX_WORD.valid || !m_need);
	wire s_start = en && !master && !busy && selected && !three;
	wire start   = m_start || s_start;
	assign TX_TAKE = start && TX_WORD.valid;
	wire [31:0] load_w  = TX_WORD.valid ? TX_WORD.data : 32'h0;
	wire [5:0]  len0    = three ? cmd_len : wlen;
	wire [31:0] tx_init = scc_order(load_w, len0,
		ctrl_b_reg[TORD_LSB +: 2]) << (6'd32 - len0);
	wire [5:0]  cur_len = (state_reg == ST_SHIFT) ? len0 : wlen;
	wire [31:0] rx_next = {rx_sh_reg[30:0], sdi};
	wire [31:0] rx_fin  = sample ? rx_next : rx_sh_reg;
	wire last  = toggle && trail && bit_cnt_reg + 6'h01 == cur_len;
	wire push  = last && (state_reg == ST_RECV
		|| (!three && mode_reg != MODE_TXONLY));
	wire [4:0] gap_end = 5'({gap, 1'b0} - 5'h01);

	always_ff @(posedge MCLK) begin
		if (RST || !en || (!master && !selected)) begin
			state_reg   <= ST_IDLE;
			tx_sh_reg   <= 32'h0;
			rx_sh_reg   <= 32'h0;
			out_reg     <= 1'b0;
			bit_cnt_reg <= 6'h0;
			gap_cnt_reg <= 5'h0;
			mode_reg    <= 2'h0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg   <= ST_SHIFT;
						mode_reg    <= mode_fld;
						bit_cnt_reg <= 6'h0;
						rx_sh_reg   <= 32'h0;
						if (!cpha) begin
							out_reg   <= tx_init[31];
							tx_sh_reg <= tx_init << 1;
						end else begin
							tx_sh_reg <= tx_init;
						end
					end
				end
				ST_SHIFT, ST_RECV: begin
					if (sample) begin
						rx_sh_reg <= rx_next;
					end
					if (shiftv && state_reg == ST_SHIFT) begin
						out_reg   <= tx_sh_reg[31];
						tx_sh_reg <= tx_sh_reg << 1;
					end
					if (trail) begin
						bit_cnt_reg <= bit_cnt_reg + 6'h01;
					end
					if (last) begin
						bit_cnt_reg <= 6'h0;
						gap_cnt_reg <= 5'h0;
						if (state_reg == ST_SHIFT && three) begin
							// Command done, now the response
							rx_sh_reg <= 32'h0;
							state_reg <= wait_en ? ST_WAIT : ST_RECV;
						end else if (state_reg == ST_SHIFT && master
							&& gap != 4'h0) begin
							state_reg <= ST_GAP;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_WAIT: begin
					if (tick) begin
						gap_cnt_reg <= gap_cnt_reg + 5'h01;
						if (gap_cnt_reg == 5'h01) begin
							state_reg <= ST_RECV;
						end
					end
				end
				ST_GAP: begin
					if (tick) begin
						gap_cnt_reg <= gap_cnt_reg + 5'h01;
						if (gap_cnt_reg == gap_end) begin
							state_reg <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			rx_word_reg <= '0;
		end else begin
			rx_word_reg.valid <= push;
			if (push) begin
				rx_word_reg.data <= scc_order(rx_fin, wlen,
					ctrl_b_reg[RORD_LSB +: 2]);
			end
		end
	end

	// Pin drive
	assign RX_WORD = rx_word_reg;
	assign SCLK_O  = sclk_reg;
	assign SCLK_OE = en && master;
	assign SDO_O   = out_reg;
	// Shared data pin turns round for the three-wire response
	assign SDO_OE  = en && (master ? !(three && state_reg == ST_RECV)
		: (selected && !slave_output_disable));
	assign CS1_N_O = ctrl_a_reg[TSEL_BIT];

	chk_select_pin: assert property (wr_a && wr_strb[3]
		|=> CS1_N_O == $past(wr_data[TSEL_BIT]))
		else $error("select pin did not follow its bit");
	chk_idle_level: assert property ($past(state_reg == ST_IDLE)
		&& !busy && $stable(ctrl_a_reg) && master |-> SCLK_O == idle_lvl)
		else $error("serial clock not at idle level");
	chk_half_period: assert property (state_reg == ST_SHIFT && master
		&& $past(m_run) && $changed(sclk_reg)
		|-> $past(half_cnt_reg) == $past(half_len) - 16'h0001)
		else $error("clock edge off the divider count");
	chk_word_bits: assert property (push
		|-> bit_cnt_reg == wlen - 6'h01)
		else $error("word ended at the wrong bit count");
	chk_txonly_norx: assert property (RX_WORD.valid && !three
		|-> $past(mode_reg) != MODE_TXONLY)
		else $error("receive word in transmit only mode");
	chk_mode_latch: assert property (busy && $past(busy)
		|-> $stable(mode_reg))
		else $error("mode changed inside a word");
	chk_sod_quiet: assert property (!master && slave_output_disable |-> !SDO_OE)
		else $error("slave drove data with output disabled");
	chk_gap_len: assert property (state_reg == ST_GAP && tick
		&& gap_cnt_reg == gap_end |=> state_reg == ST_IDLE)
		else $error("frame gap length wrong");
	chk_wait_ins: assert property ($past(state_reg == ST_SHIFT)
		&& (state_reg == ST_WAIT || state_reg == ST_RECV)
		|-> (state_reg == ST_WAIT) == $past(wait_en))
		else $error("wait state insertion wrong");
	chk_disable_idle: assert property (!en |=> !busy)
		else $error("engine active while disabled");
	chk_in_delay: assert property (delay_en && $past(RST, 3) == 1'b0
		|-> sdi == $past(in_sync_reg[0], IN_DELAY_CYCLES))
		else $error("input delay not two cycles");
endmodule : scc_link

// ===== tb/scc_target.sv
`timescale 1ns/1ns
module scc_target (
	// Serial pins
	input  wire logic       SCLK,
	input  wire logic       CS_N,
	input  wire logic       MOSI,
	output      logic       MISO,
	// Answer word and captured word
	input  wire logic [7:0] REPLY,
	output      logic [7:0] GOT
);
	int   idx = 7;
	logic last = 1'b0;

	// Mode zero target: capture on rise, advance on fall
	always @(negedge CS_N) idx = 7;
	always @(posedge SCLK) if (!CS_N) GOT <= {GOT[6:0], MOSI};
	always @(negedge SCLK) if (!CS_N && idx > 0) idx = idx - 1;
	always @(posedge SCLK) if (!CS_N) last <= MISO;
	// Released line shows the inverse so a stale bit never passes
	assign MISO = CS_N ? ~last : REPLY[idx];
endmodule : scc_target

// ===== tb/test_spi_control_configuration.sv
`timescale 1ns/1ns
module test_spi_control_configuration;
	import scc_pkg::*;
	logic        mclk, rst, awv, wv, brdy, arv, rrdy, awr, wr, bv, arr;
	logic        rv, ttrig, rtrig, take, sck, sck_oe, sdo, sdo_oe, sdi;
	logic        ss_n, cs_n, sck_q, polling;
	logic [7:0]  awa, ara, reply, got;
	logic [31:0] wd, rd;
	logic [1:0]  br, rr;
	logic [4:0]  tlv, rlv;
	scc_word_t   txw, rxw;
	logic [33:0] rd_q[$];
	logic [7:0]  rx_q[$];
	int          errors, samples_checked, seed, cnt, period;
	logic [4:0]  lvls [0:7] = '{5'h0, 5'h1, 5'h3, 5'h4, 5'h7, 5'h8, 5'h9,
		5'h1f};

	scc_link dut (
		.MCLK(mclk), .RST(rst),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .TX_WORD(txw),
		.TX_TAKE(take), .RX_WORD(rxw), .TX_LEVEL(tlv), .RX_LEVEL(rlv),
		.TX_TRIGGER(ttrig), .RX_TRIGGER(rtrig), .SCLK_I(1'b0),
		.SCLK_O(sck), .SCLK_OE(sck_oe), .SDO_O(sdo), .SDO_OE(sdo_oe),
		.SDI_I(sdi), .SS_N_I(ss_n), .CS1_N_O(cs_n)
	);
	scc_target far (.SCLK(sck), .CS_N(cs_n), .MOSI(sdo), .MISO(sdi),
		.REPLY(reply), .GOT(got));

	task automatic check(input logic [33:0] g, input logic [33:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check

	task automatic complete_run;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task automatic give_up;
		check(34'h0, 34'h1);
		complete_run();
	endtask : give_up

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int n;
		n = 0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge mclk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			n++;
		end while (!bv && n < 200);
		if (!bv) give_up();
		check({32'h0, br}, {32'h0, e});
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		int n;
		n = 0;
		ara <= a;
		arv <= 1'b1;
		do begin
			@(posedge mclk);
			if (arr) arv <= 1'b0;
			n++;
		end while (!rv && n < 200);
		v = rd;
		if (!rv) give_up();
	endtask : rd_reg

	task automatic expect_rd(input logic [7:0] a, input logic [1:0] e,
		input logic [31:0] d);
		logic [31:0] v;
		rd_q.push_back({e, d});
		rd_reg(a, v);
	endtask : expect_rd

	function automatic logic [7:0] rev8(input logic [7:0] x);
		for (int i = 0; i < 8; i++) rev8[i] = x[7 - i];
	endfunction : rev8

	function automatic logic [31:0] cfg(input logic [1:0] m,
		input logic [7:0] r, input logic idle, input logic tsel);
		cfg = 32'h7;
		cfg[IDLE_BIT] = idle;
		cfg[RATE_LSB +: 8] = r;
		cfg[MODE_LSB +: 2] = m;
		cfg[TSEL_BIT] = tsel;
	endfunction : cfg

	function automatic logic trig(input logic [2:0] c, input logic [4:0] l);
		trig = (c == 0) ? l >= 1 : (c == 1) ? l >= 4 : (c == 2) ? l >= 8
			: 1'b0;
	endfunction : trig

	// One eight-bit word; far side answers in mode zero
	task automatic xfer(input logic [1:0] m, input logic [1:0] o,
		input logic [7:0] r);
		logic [7:0]  d, q;
		logic [31:0] v;
		int          n;
		d = 8'($random(seed));
		q = 8'($random(seed));
		reply <= q;
		wr_reg(ADDR_CTRL_A, cfg(m, r, 1'b0, 1'b0), RESP_OKAY);
		repeat (2) @(posedge mclk);
		check({33'h0, cs_n}, 34'h0);
		if (m != MODE_TXONLY) rx_q.push_back(o[0] ? rev8(q) : q);
		// Word offered first: receive only would start without it
		txw <= {1'b1, 24'h0, d};
		wr_reg(ADDR_CTRL_B, (32'(o) << RORD_LSB) | (32'(o) << TORD_LSB)
			| (32'(m) << GAP_LSB) | (32'(r[0]) << DELAY_BIT) | 32'h2,
			RESP_OKAY);
		n = 0;
		while (!take && n < 200) begin
			@(posedge mclk);
			n++;
		end
		txw.valid <= 1'b0;
		if (!take) give_up();
		// New mode only for the next word, so receive only stops after one
		wr_reg(ADDR_CTRL_A, cfg(2'h0, r, 1'b0, 1'b0), RESP_OKAY);
		polling <= 1'b1;
		n = 0;
		do begin
			rd_reg(ADDR_STATUS, v);
			n++;
		end while (v[0] && n < 200);
		polling <= 1'b0;
		if (v[0]) give_up();
		check({26'h0, got}, {26'h0, o[0] ? rev8(d) : d});
		check(34'(period), 34'(8 * (1 + r)));
		wr_reg(ADDR_CTRL_B, 32'h0, RESP_OKAY);
		wr_reg(ADDR_CTRL_A, cfg(m, r, 1'b0, 1'b1), RESP_OKAY);
		repeat (2) @(posedge mclk);
		check({33'h0, cs_n}, 34'h1);
		check(34'(rx_q.size()), 34'h0);
	endtask : xfer

	// Status polls are skipped, their value is not known ahead
	always @(posedge mclk) begin
		if (rv && rrdy && !polling)
			check({rr, rd}, rd_q.size() ? rd_q.pop_front() : ~{rr, rd});
		if (rxw.valid)
			check({26'h0, rxw.data[7:0]},
				{26'h0, rx_q.size() ? rx_q.pop_front() : ~rxw.data[7:0]});
		sck_q <= sck;
		cnt <= (sck && !sck_q) ? 0 : cnt + 1;
		if (sck && !sck_q) period <= cnt + 1;
	end

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		logic [31:0] v;
		seed = 80;
		errors = 0;
		samples_checked = 0;
		{rst, ss_n} = 2'b11;
		{awv, wv, arv, polling, sck_q} = '0;
		{brdy, rrdy} = 2'b11;
		{awa, ara, wd, reply, tlv, rlv, cnt, period} = '0;
		txw = '0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check({33'h0, cs_n}, 34'h1);
		expect_rd(ADDR_CTRL_A, RESP_OKAY, CTRL_A_RESET);
		expect_rd(ADDR_CTRL_B, RESP_OKAY, CTRL_B_RESET);
		expect_rd(ADDR_PRESCALE, RESP_OKAY, 32'h0);
		expect_rd(8'h08, RESP_SLVERR, 32'h0);
		wr_reg(8'h08, $random(seed), RESP_SLVERR);
		v = $random(seed) & 32'hfffffff9;
		wr_reg(ADDR_CTRL_B, v, RESP_OKAY);
		expect_rd(ADDR_CTRL_B, RESP_OKAY, v);
		for (int c = 0; c < 4; c++) begin
			wr_reg(ADDR_CTRL_B, (32'(c) << RTRIG_LSB) | (32'(c) << TTRIG_LSB),
				RESP_OKAY);
			for (int i = 0; i < 8; i++) begin
				tlv <= lvls[i];
				rlv <= lvls[7 - i];
				@(negedge mclk);
				check({32'h0, ttrig, rtrig}, {32'h0, trig(3'(c), lvls[i]),
					trig(3'(c), lvls[7 - i])});
				@(posedge mclk);
			end
		end
		wr_reg(ADDR_CTRL_B, 32'h0000000e, RESP_OKAY);
		ss_n <= 1'b0;
		repeat (16) begin
			@(negedge mclk);
			check({32'h0, sdo_oe, sck_oe}, 34'h0);
		end
		@(posedge mclk);
		ss_n <= 1'b1;
		wr_reg(ADDR_CTRL_B, 32'h0, RESP_OKAY);
		wr_reg(ADDR_CTRL_A, cfg(2'h0, 8'h0, 1'b1, 1'b1), RESP_OKAY);
		txw <= {1'b1, 32'h5a};
		repeat (16) begin
			@(negedge mclk);
			check({32'h0, take, sck_oe}, 34'h0);
		end
		@(posedge mclk);
		txw.valid <= 1'b0;
		wr_reg(ADDR_CTRL_B, 32'h2, RESP_OKAY);
		repeat (3) @(posedge mclk);
		check({32'h0, sck, sck_oe}, 34'h3);
		wr_reg(ADDR_CTRL_B, 32'h0, RESP_OKAY);
		wr_reg(ADDR_CTRL_A, cfg(2'h0, 8'h0, 1'b0, 1'b1), RESP_OKAY);
		// Slow enough for the two-stage input sync plus the input delay
		wr_reg(ADDR_PRESCALE, 32'h8, RESP_OKAY);
		for (int k = 0; k < 8; k++)
			xfer(2'(k), k[2] ? 2'h3 : 2'h0, 8'(k[0]));
		complete_run();
	end
endmodule : test_spi_control_configuration
